//--- fbp_consts.svh
// Offsets, field positions, codes and reset values of the fieldbus block
`ifndef FBP_CONSTS_SVH
`define FBP_CONSTS_SVH

// Written variable set, contiguous from offset zero
`define FBP_W_CTRL 4'h0
`define FBP_W_SPEED 4'h1
`define FBP_W_DOUT 4'h2
`define FBP_W_RDNUM 4'h3
`define FBP_W_WRNUM 4'h4
`define FBP_W_WRVAL 4'h5
// Read variable set, contiguous from offset zero
`define FBP_R_STATUS 4'h0
`define FBP_R_SPEED 4'h1
`define FBP_R_DOUT 4'h2
`define FBP_R_PCONT 4'h3
// Local configuration, same offsets for write and read
`define FBP_C_STD 4'h8
`define FBP_C_ACTION 4'h9
`define FBP_C_FNMASK 4'hA
`define FBP_C_DOMASK 4'hB

// Parameter numbers and the parameter reset value
`define FBP_IDLE_NUM 16'h03E7
`define FBP_PROT_PARAM_A 16'h0198
`define FBP_PROT_PARAM_B 16'h00CC
`define FBP_PARAM_RESET 16'h0000

// Request fault codes
`define FBP_CODE_NONE 8'h00
`define FBP_CODE_WR_ENABLED 8'h18
`define FBP_CODE_MISSING 8'h19
`define FBP_CODE_RANGE 8'h1A
`define FBP_CODE_NOT_ASSIGNED 8'h1B

// Control word fields
`define FBP_CL_SEL_LSB 8
`define FBP_CL_START 0
`define FBP_CL_ENABLE 1
`define FBP_CL_DIR 2
`define FBP_CL_JOG 3
`define FBP_CL_REMOTE 4
`define FBP_CL_NOSAVE 5
`define FBP_CL_FRESET 7
`define FBP_CL_NOFUNC 6

// Output word fields
`define FBP_DO_SEL_LSB 8
`define FBP_DO_COUNT 5

// Status word fields
`define FBP_ST_LINK 15
`define FBP_ST_BOARD 14
`define FBP_ST_RUN 13
`define FBP_ST_EN 12
`define FBP_ST_DIR 11
`define FBP_ST_JOG 10
`define FBP_ST_REMOTE 9

`endif

//--- fbp_pkg.sv
// Types shared by the fieldbus parameter block
package fbp_pkg;
	typedef enum logic [1:0] {
		FBP_SRC_NONE,
		FBP_SRC_FUNC,
		FBP_SRC_DOUT,
		FBP_SRC_OTHER
	} fbp_src_t;

	typedef enum logic [1:0] {
		FBP_ACT_NONE,
		FBP_ACT_RAMP_STOP,
		FBP_ACT_DISABLE,
		FBP_ACT_TRIP
	} fbp_action_t;

	typedef struct packed {
		logic read_only;
		logic disabled_only;
		logic [15:0] min_val;
		logic [15:0] max_val;
	} fbp_attr_t;
endpackage

//--- fbp_chk_if.sv
// Request and verdict between the register side and the parameter checker
`timescale 1ns/10ps
interface fbp_chk_if;
	logic [15:0] rd_num;
	logic [15:0] wr_num;
	logic [15:0] wr_val;
	logic drive_enabled;
	logic [7:0] rd_fault;
	logic [7:0] wr_fault;

	modport requester (output rd_num, output wr_num, output wr_val,
		output drive_enabled, input rd_fault, input wr_fault);
	modport checker_side (input rd_num, input wr_num, input wr_val,
		input drive_enabled, output rd_fault, output wr_fault);
endinterface

//--- fbp_param_check.sv
// Combinational check of parameter read and write requests
`timescale 1ns/10ps
`include "fbp_consts.svh"
module fbp_param_check #(
	parameter int PARAM_COUNT = 16
) (
	fbp_chk_if.checker_side chk
);
	import fbp_pkg::*;

	function automatic logic exists(input logic [15:0] num);
		exists = (num < 16'(PARAM_COUNT));
	endfunction

	// Low numbers are monitoring values, the next block is drive setup
	function automatic fbp_attr_t attr(input logic [15:0] num);
		attr = '{read_only: 1'b0, disabled_only: 1'b0,
			min_val: 16'h0000, max_val: 16'h7FFF};
		if (num < 16'h0004) begin
			attr.read_only = 1'b1;
		end else if (num < 16'h0008) begin
			attr.disabled_only = 1'b1;
			attr.max_val = 16'h03E8;
		end
	endfunction

	always_comb begin
		fbp_attr_t a;
		a = attr(chk.wr_num);
		chk.rd_fault = exists(chk.rd_num) ? `FBP_CODE_NONE : `FBP_CODE_MISSING;
		if (!exists(chk.wr_num) || chk.wr_num == `FBP_PROT_PARAM_A ||
			chk.wr_num == `FBP_PROT_PARAM_B) begin
			chk.wr_fault = `FBP_CODE_MISSING;
		end else if (a.read_only) begin
			chk.wr_fault = `FBP_CODE_NOT_ASSIGNED;
		end else if (a.disabled_only && chk.drive_enabled) begin
			chk.wr_fault = `FBP_CODE_WR_ENABLED;
		end else if (chk.wr_val < a.min_val || chk.wr_val > a.max_val) begin
			chk.wr_fault = `FBP_CODE_RANGE;
		end else begin
			chk.wr_fault = `FBP_CODE_NONE;
		end
	end
endmodule // fbp_param_check

//--- fbp_top.sv
// Fieldbus parameter write handling and fault flags of the logical status
`timescale 1ns/10ps
`include "fbp_consts.svh"
module fbp_top #(
	parameter int PARAM_COUNT = 16,
	parameter int STD_WIDTH = 3
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic drive_enabled_i,
	input wire logic link_up_i,
	input wire logic board_present_i,
	input wire logic board_ok_i,
	input wire logic [STD_WIDTH-1:0] board_std_i,
	input wire logic programming_key_i,
	output logic start_o,
	output logic enable_o,
	output logic dir_cw_o,
	output logic jog_o,
	output logic remote_o,
	output logic save_inhibit_o,
	output logic fault_reset_o,
	output logic [4:0] dig_out_o,
	output logic [15:0] speed_ref_o,
	output logic link_lost_fault_o,
	output logic interface_board_fault_o,
	output fbp_pkg::fbp_action_t comm_action_o
);
	import fbp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [15:0] ctrl_reg;
	logic [15:0] dout_word_reg;
	logic [15:0] rdnum_reg;
	logic [15:0] wrnum_reg;
	logic [15:0] wrval_reg;
	logic [STD_WIDTH-1:0] std_sel_reg;
	fbp_action_t action_set_reg;
	logic [7:0] fn_mask_reg;
	logic [4:0] do_mask_reg;
	logic [15:0] param_reg [PARAM_COUNT];
	logic [7:0] req_fault_reg;
	logic [7:0] req_fault_next;
	fbp_src_t req_src_reg;
	fbp_src_t req_src_next;
	logic [1:0] link_sync_reg;
	logic [1:0] present_sync_reg;
	logic [1:0] ok_sync_reg;
	logic [1:0] key_sync_reg;
	logic [STD_WIDTH-1:0] std_sync1_reg;
	logic [STD_WIDTH-1:0] std_sync2_reg;
	logic key_prev_reg;
	logic link_bad_prev_reg;
	logic board_bad_prev_reg;

	logic wr_ctrl;
	logic wr_dout;
	logic wr_rdnum;
	logic wr_wrnum;
	logic wr_wrval;
	logic func_bad;
	logic dout_bad;
	logic wr_attempt;
	logic raise;
	logic [7:0] raise_code;
	fbp_src_t raise_src;
	logic clr_other;
	logic clr_assign;
	logic link_bad;
	logic board_bad;
	logic link_event;
	logic board_event;
	logic key_press;
	logic freset_cmd;
	logic [7:0] cl_sel;

	fbp_chk_if chk ();

	fbp_param_check #(
		.PARAM_COUNT(PARAM_COUNT)
	) u_check (
		.chk(chk)
	);

	////////////////////////////////////////////////////////////////////////
	// Write decode

	function automatic logic hit(input logic [3:0] off);
		hit = reg_wr_i && reg_addr_i == off;
	endfunction

	assign wr_ctrl = hit(`FBP_W_CTRL);
	assign wr_dout = hit(`FBP_W_DOUT);
	assign wr_rdnum = hit(`FBP_W_RDNUM);
	assign wr_wrnum = hit(`FBP_W_WRNUM);
	assign wr_wrval = hit(`FBP_W_WRVAL);
	assign cl_sel = reg_wdata_i[15:`FBP_CL_SEL_LSB];

	// Bit 6 needs no select; bit 14 has no function
	assign func_bad = |(cl_sel & ~fn_mask_reg & 8'hBF);
	assign dout_bad = |(reg_wdata_i[12:`FBP_DO_SEL_LSB] & ~do_mask_reg);

	assign chk.rd_num = reg_wdata_i;
	assign chk.wr_num = wr_wrnum ? reg_wdata_i : wrnum_reg;
	assign chk.wr_val = wr_wrval ? reg_wdata_i : wrval_reg;
	assign chk.drive_enabled = drive_enabled_i;

	// A write is tried only while a real number sits in the slot
	assign wr_attempt = (wr_wrnum && reg_wdata_i != `FBP_IDLE_NUM) ||
		(wr_wrval && wrnum_reg != `FBP_IDLE_NUM);

	////////////////////////////////////////////////////////////////////////
	// Request fault events

	always_comb begin
		raise = 1'b0;
		raise_code = `FBP_CODE_NONE;
		raise_src = FBP_SRC_NONE;
		clr_other = 1'b0;
		clr_assign = 1'b0;
		if (wr_ctrl) begin
			if (func_bad) begin
				raise = 1'b1;
				raise_code = `FBP_CODE_NOT_ASSIGNED;
				raise_src = FBP_SRC_FUNC;
			end else begin
				clr_other = 1'b1;
			end
			clr_assign = reg_wdata_i != ctrl_reg;
		end else if (wr_dout) begin
			if (dout_bad) begin
				raise = 1'b1;
				raise_code = `FBP_CODE_NOT_ASSIGNED;
				raise_src = FBP_SRC_DOUT;
			end else begin
				clr_other = 1'b1;
			end
		end else if (wr_rdnum) begin
			if (chk.rd_fault != `FBP_CODE_NONE) begin
				raise = 1'b1;
				raise_code = chk.rd_fault;
				raise_src = FBP_SRC_OTHER;
			end else begin
				clr_other = 1'b1;
			end
		end else if (wr_attempt) begin
			if (chk.wr_fault != `FBP_CODE_NONE) begin
				raise = 1'b1;
				raise_code = chk.wr_fault;
				raise_src = FBP_SRC_OTHER;
			end else begin
				clr_other = 1'b1;
			end
		end else if (wr_wrnum) begin
			clr_other = 1'b1;
		end
	end

	always_comb begin
		req_fault_next = req_fault_reg;
		req_src_next = req_src_reg;
		if (raise) begin
			req_fault_next = raise_code;
			req_src_next = raise_src;
		end else if ((clr_assign && (req_src_reg == FBP_SRC_FUNC ||
			req_src_reg == FBP_SRC_DOUT)) ||
			(clr_other && req_src_reg == FBP_SRC_OTHER)) begin
			req_fault_next = `FBP_CODE_NONE;
			req_src_next = FBP_SRC_NONE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			req_fault_reg <= `FBP_CODE_NONE;
			req_src_reg <= FBP_SRC_NONE;
		end else begin
			req_fault_reg <= req_fault_next;
			req_src_reg <= req_src_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Written variables and configuration

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= 16'h0000;
			dout_word_reg <= 16'h0000;
			speed_ref_o <= 16'h0000;
			rdnum_reg <= 16'h0000;
			wrnum_reg <= `FBP_IDLE_NUM;
			wrval_reg <= 16'h0000;
			std_sel_reg <= '0;
			action_set_reg <= FBP_ACT_NONE;
			fn_mask_reg <= 8'h00;
			do_mask_reg <= 5'h00;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`FBP_W_CTRL: ctrl_reg <= reg_wdata_i;
				`FBP_W_SPEED: speed_ref_o <= reg_wdata_i;
				`FBP_W_DOUT: dout_word_reg <= reg_wdata_i;
				`FBP_W_RDNUM: rdnum_reg <= reg_wdata_i;
				`FBP_W_WRNUM: wrnum_reg <= reg_wdata_i;
				`FBP_W_WRVAL: wrval_reg <= reg_wdata_i;
				`FBP_C_STD: std_sel_reg <= reg_wdata_i[STD_WIDTH-1:0];
				`FBP_C_ACTION: action_set_reg <= fbp_action_t'(reg_wdata_i[1:0]);
				`FBP_C_FNMASK: fn_mask_reg <= reg_wdata_i[7:0];
				`FBP_C_DOMASK: do_mask_reg <= reg_wdata_i[4:0];
				default: ;
			endcase
		end
	end

	// Accepted parameter writes land in the store
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < PARAM_COUNT; i++) begin
				param_reg[i] <= `FBP_PARAM_RESET;
			end
		end else if (wr_attempt && chk.wr_fault == `FBP_CODE_NONE) begin
			param_reg[chk.wr_num[$clog2(PARAM_COUNT)-1:0]] <= chk.wr_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drive commands; a write that raises a request fault changes none of them

	assign freset_cmd = wr_ctrl && !func_bad &&
		reg_wdata_i[`FBP_CL_SEL_LSB+`FBP_CL_FRESET] &&
		reg_wdata_i[`FBP_CL_FRESET] && !ctrl_reg[`FBP_CL_FRESET];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			start_o <= 1'b0;
			enable_o <= 1'b0;
			dir_cw_o <= 1'b0;
			jog_o <= 1'b0;
			remote_o <= 1'b0;
			save_inhibit_o <= 1'b0;
			fault_reset_o <= 1'b0;
		end else begin
			fault_reset_o <= freset_cmd;
			if (wr_ctrl && !func_bad) begin
				if (cl_sel[`FBP_CL_START]) start_o <= reg_wdata_i[`FBP_CL_START];
				if (cl_sel[`FBP_CL_ENABLE]) enable_o <= reg_wdata_i[`FBP_CL_ENABLE];
				if (cl_sel[`FBP_CL_DIR]) dir_cw_o <= reg_wdata_i[`FBP_CL_DIR];
				if (cl_sel[`FBP_CL_JOG]) jog_o <= reg_wdata_i[`FBP_CL_JOG];
				if (cl_sel[`FBP_CL_REMOTE]) remote_o <= reg_wdata_i[`FBP_CL_REMOTE];
				if (cl_sel[`FBP_CL_NOSAVE]) save_inhibit_o <= reg_wdata_i[`FBP_CL_NOSAVE];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			dig_out_o <= 5'h00;
		end else if (wr_dout && !dout_bad) begin
			for (int i = 0; i < `FBP_DO_COUNT; i++) begin
				if (reg_wdata_i[`FBP_DO_SEL_LSB+i]) begin
					dig_out_o[i] <= reg_wdata_i[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			link_sync_reg <= 2'b00;
			present_sync_reg <= 2'b00;
			ok_sync_reg <= 2'b00;
			key_sync_reg <= 2'b00;
			std_sync1_reg <= '0;
			std_sync2_reg <= '0;
		end else begin
			link_sync_reg <= {link_sync_reg[0], link_up_i};
			present_sync_reg <= {present_sync_reg[0], board_present_i};
			ok_sync_reg <= {ok_sync_reg[0], board_ok_i};
			key_sync_reg <= {key_sync_reg[0], programming_key_i};
			std_sync1_reg <= board_std_i;
			std_sync2_reg <= std_sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link and board faults

	assign link_bad = std_sel_reg != '0 && !link_sync_reg[1];
	assign board_bad = std_sel_reg != '0 && (!present_sync_reg[1] ||
		!ok_sync_reg[1] || std_sync2_reg != std_sel_reg);
	assign link_event = link_bad && !link_bad_prev_reg;
	assign board_event = board_bad && !board_bad_prev_reg;
	assign key_press = key_sync_reg[1] && !key_prev_reg;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			link_bad_prev_reg <= 1'b0;
			board_bad_prev_reg <= 1'b0;
			key_prev_reg <= 1'b0;
			link_lost_fault_o <= 1'b0;
			interface_board_fault_o <= 1'b0;
		end else begin
			link_bad_prev_reg <= link_bad;
			board_bad_prev_reg <= board_bad;
			key_prev_reg <= key_sync_reg[1];
			if (link_event) begin
				link_lost_fault_o <= 1'b1;
			end else if (key_press) begin
				link_lost_fault_o <= 1'b0;
			end
			if (board_event) begin
				interface_board_fault_o <= 1'b1;
			end else if (key_press) begin
				interface_board_fault_o <= 1'b0;
			end
		end
	end

	// Reaction holds until a fault reset with both conditions gone
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			comm_action_o <= FBP_ACT_NONE;
		end else if (link_event || board_event) begin
			comm_action_o <= action_set_reg;
		end else if (freset_cmd && !link_bad && !board_bad) begin
			comm_action_o <= FBP_ACT_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read variables

	function automatic logic [15:0] status_word();
		logic [15:0] s;
		s = 16'h0000;
		s[7:0] = req_fault_reg;
		s[`FBP_ST_LINK] = link_bad;
		s[`FBP_ST_BOARD] = board_bad;
		s[`FBP_ST_RUN] = start_o;
		s[`FBP_ST_EN] = enable_o;
		s[`FBP_ST_DIR] = dir_cw_o;
		s[`FBP_ST_JOG] = jog_o;
		s[`FBP_ST_REMOTE] = remote_o;
		return s;
	endfunction

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`FBP_R_STATUS: reg_rdata_o <= status_word();
				`FBP_R_SPEED: reg_rdata_o <= speed_ref_o;
				`FBP_R_DOUT: reg_rdata_o <= {11'h000, dig_out_o};
				`FBP_R_PCONT: reg_rdata_o <= (rdnum_reg < 16'(PARAM_COUNT)) ?
					param_reg[rdnum_reg[$clog2(PARAM_COUNT)-1:0]] : 16'h0000;
				`FBP_C_STD: reg_rdata_o <= 16'(std_sel_reg);
				`FBP_C_ACTION: reg_rdata_o <= {14'h0000, action_set_reg};
				`FBP_C_FNMASK: reg_rdata_o <= {8'h00, fn_mask_reg};
				`FBP_C_DOMASK: reg_rdata_o <= {11'h000, do_mask_reg};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end
endmodule // fbp_top

//--- fbp_master_model.sv
// Register-side master that drives the fieldbus request words
`timescale 1ns/10ps
module fbp_master_model (
	input wire logic sys_clk_i,
	output logic [3:0] reg_addr_o,
	output logic [15:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [15:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 4'h0;
		reg_wdata_o = 16'h0000;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	////////////////////////////////////////
	// Values are already scaled integers
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_o <= a;
		// The written word stays on the bus until the next write
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_o <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o <= 1'b0;
		@(posedge sys_clk_i);
		d = reg_rdata_i;
	endtask
endmodule // fbp_master_model

//--- fbp_top_monitor.sv
// Port-level checks of the fieldbus parameter block
`timescale 1ns/10ps
module fbp_top_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic link_up_i,
	input wire logic board_present_i,
	input wire logic board_ok_i,
	input wire logic programming_key_i,
	input wire logic start_o,
	input wire logic enable_o,
	input wire logic fault_reset_o,
	input wire logic [4:0] dig_out_o,
	input wire logic [15:0] speed_ref_o,
	input wire logic link_lost_fault_o,
	input wire logic interface_board_fault_o,
	input wire fbp_pkg::fbp_action_t comm_action_o
);
	import fbp_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_rdata_slot: assert property (reg_rdata_o != 16'h0000 |->
		$past(reg_rd_i)) else $error("read data outside slot");
	chk_start_cause: assert property ($changed(start_o) |->
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h0) else $error("start");
	chk_enable_cause: assert property ($changed(enable_o) |->
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h0) else $error("enable");
	chk_dout_cause: assert property ($changed(dig_out_o) |->
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h2) else $error("dout");
	chk_speed_cause: assert property ($changed(speed_ref_o) |->
		$past(reg_wr_i) && $past(reg_addr_i) == 4'h1) else $error("speed");
	chk_reset_pulse: assert property (fault_reset_o |=>
		!fault_reset_o) else $error("fault reset not a pulse");
	chk_link_cause: assert property ($rose(link_lost_fault_o) |->
		!$past(link_up_i, 3))
		else $error("link fault without lost link");
	chk_key_clear: assert property (($rose(programming_key_i) &&
		link_up_i && board_present_i && board_ok_i) |-> ##[1:6]
		(!link_lost_fault_o && !interface_board_fault_o))
		else $error("key did not clear flags");
	chk_action_cause: assert property ($changed(comm_action_o) |->
		$rose(link_lost_fault_o) || $rose(interface_board_fault_o) ||
		fault_reset_o || $past(fault_reset_o)) else $error("action");

	cover property ($rose(link_lost_fault_o));
	cover property ($rose(interface_board_fault_o));
	cover property (fault_reset_o);
endmodule // fbp_top_monitor

bind fbp_top fbp_top_monitor u_mon (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.link_up_i(link_up_i),
	.board_present_i(board_present_i),
	.board_ok_i(board_ok_i),
	.programming_key_i(programming_key_i),
	.start_o(start_o),
	.enable_o(enable_o),
	.fault_reset_o(fault_reset_o),
	.dig_out_o(dig_out_o),
	.speed_ref_o(speed_ref_o),
	.link_lost_fault_o(link_lost_fault_o),
	.interface_board_fault_o(interface_board_fault_o),
	.comm_action_o(comm_action_o)
);

//--- fbp_top_tb.sv
// Self-checking bench for the fieldbus parameter block
`timescale 1ns/10ps
module fbp_top_tb;
	import fbp_pkg::*;
	logic clk, rst_b, en, link, present, ok, key, wr, rd;
	logic start, enab, frst, lflt, bflt, dir, jog, remote, noss;
	logic [2:0] board_std;
	logic [3:0] addr;
	logic [4:0] dout;
	logic [15:0] wdata, rdata, spd, rv;
	fbp_action_t act;
	int err_count, samples_checked;
	// Entry: offset, data, expected status, drive enabled
	logic [36:0] steps [$] = '{
		{4'h4, 16'h0198, 16'h0019, 1'b0},
		{4'h4, 16'h03E7, 16'h0000, 1'b0},
		{4'h4, 16'h00CC, 16'h0019, 1'b0},
		{4'h4, 16'h03E7, 16'h0000, 1'b0},
		{4'h3, 16'h0010, 16'h0019, 1'b0},
		{4'h3, 16'h0004, 16'h0000, 1'b0},
		{4'h4, 16'h0000, 16'h001B, 1'b0},
		{4'h4, 16'h03E7, 16'h0000, 1'b0},
		{4'h4, 16'h0004, 16'h0018, 1'b1},
		{4'h5, 16'h03E9, 16'h001A, 1'b0},
		{4'h5, 16'h03E8, 16'h0000, 1'b0},
		{4'h4, 16'h03E7, 16'h0000, 1'b0},
		{4'h0, 16'h0101, 16'h001B, 1'b0},
		{4'hA, 16'h00FF, 16'h001B, 1'b0},
		{4'h4, 16'h03E7, 16'h001B, 1'b0},
		{4'h0, 16'h0103, 16'h2000, 1'b0},
		{4'h2, 16'h0111, 16'h201B, 1'b0},
		{4'h0, 16'h0103, 16'h201B, 1'b0},
		{4'h2, 16'h0000, 16'h201B, 1'b0},
		{4'h0, 16'h0102, 16'h0000, 1'b0},
		{4'hB, 16'h001F, 16'h0000, 1'b0},
		{4'h2, 16'h1113, 16'h0000, 1'b0},
		{4'h1, 16'h1AAA, 16'h0000, 1'b0},
		{4'h8, 16'h0001, 16'h0000, 1'b0},
		{4'h9, 16'h0003, 16'h0000, 1'b0}
	};

	fbp_master_model mst (.sys_clk_i(clk), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_rdata_i(rdata));

	fbp_top dut (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .drive_enabled_i(en), .link_up_i(link),
		.board_present_i(present), .board_ok_i(ok),
		.board_std_i(board_std),
		.programming_key_i(key), .start_o(start), .enable_o(enab),
		.dir_cw_o(dir), .jog_o(jog), .remote_o(remote),
		.save_inhibit_o(noss),
		.fault_reset_o(frst), .dig_out_o(dout), .speed_ref_o(spd),
		.link_lost_fault_o(lflt), .interface_board_fault_o(bflt),
		.comm_action_o(act));

	////////////////////////////////////////
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("errors=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		stop_test();
	end

	initial begin
		{rst_b, en, key} = 3'h0;
		{link, present, ok} = 3'h7;
		board_std = 3'h1;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		mst.rd(4'h0, rv);
		chk_word(rv, 16'h0000);
		foreach (steps[i]) begin
			@(posedge clk);
			en <= steps[i][0];
			mst.wr(steps[i][36:33], steps[i][32:17]);
			mst.rd(4'h0, rv);
			chk_word(rv, steps[i][16:1]);
		end
		mst.rd(4'h3, rv);
		chk_word(rv, 16'h03E8);
		mst.rd(4'h1, rv);
		chk_word(rv, 16'h1AAA);
		chk_word(spd, 16'h1AAA);
		mst.rd(4'h2, rv);
		chk_word(rv, 16'h0011);
		mst.rd(4'h7, rv);
		chk_word(rv, 16'h0000);
		chk_word({11'h000, dout}, 16'h0011);
		// Board mismatch, board absent, board bad, then link lost
		for (int i = 0; i < 4; i++) begin
			board_std <= (i == 0) ? 3'h2 : 3'h1;
			present <= (i != 1);
			ok <= (i != 2);
			link <= (i != 3);
			repeat (8) @(posedge clk);
			chk_pin((i == 3) ? lflt : bflt, 1'b1);
			chk_word({14'h0, act}, {14'h0, FBP_ACT_TRIP});
			mst.rd(4'h0, rv);
			chk_word(rv, (i == 3) ? 16'h8000 : 16'h4000);
			board_std <= 3'h1;
			{link, present, ok} <= 3'h7;
			repeat (8) @(posedge clk);
			key <= 1'b1;
			repeat (8) @(posedge clk);
			key <= 1'b0;
			chk_pin(lflt | bflt, 1'b0);
		end
		// Fault reset: one-cycle pulse, reaction back to none
		mst.wr(4'h0, 16'h8080);
		@(posedge clk);
		chk_pin(frst, 1'b1);
		@(posedge clk);
		chk_pin(frst, 1'b0);
		chk_word({14'h0, act}, {14'h0, FBP_ACT_NONE});
		chk_pin(start, 1'b0);
		// Start bit set but not selected: only selected commands act
		mst.wr(4'h0, 16'h3E3F);
		@(posedge clk);
		chk_word({10'h0, start, enab, dir, jog, remote, noss},
			16'h001F);
		stop_test();
	end
endmodule // fbp_top_tb
